// [verilog/sfc_cfg.svh]
`ifndef SFC_CFG_SVH
`define SFC_CFG_SVH

// Instruction codes.
`define SFC_OP_WREN  8'h06
`define SFC_OP_WRDI  8'h04
`define SFC_OP_RDSR  8'h05
`define SFC_OP_WRSR  8'h01
`define SFC_OP_READ  8'h03
`define SFC_OP_FREAD 8'h0B
`define SFC_OP_PP    8'h02

// Status word bit positions, writable mask and reset value.
`define SFC_ST_BUSY    0
`define SFC_ST_WEL     1
`define SFC_ST_GUARD0  2
`define SFC_ST_GUARD2  4
`define SFC_ST_LOCK    7
`define SFC_ST_WMASK   8'h9C
`define SFC_ST_RESET   8'h00

// Frame geometry.
`define SFC_ADDR_BYTES 2'h3
`define SFC_PAGE_BYTES 256
`define SFC_MIN_PP_DATA 2'h2

// Self-timed cycle lengths, rounded up to whole clocks.
`define SFC_CLK_NS     50
`define SFC_TW_NS      100000
`define SFC_TPP_NS     100000
`define SFC_TW_CYC     ((`SFC_TW_NS + `SFC_CLK_NS - 1) / `SFC_CLK_NS)
`define SFC_TPP_CYC    ((`SFC_TPP_NS + `SFC_CLK_NS - 1) / `SFC_CLK_NS)

`endif

// [verilog/sfc_pkg.sv]
package sfc_pkg;

  // One byte on the serial link or in the array.
  typedef logic [7:0] sfc_byte_t;

  // Frame decoder states.
  typedef enum logic [3:0] {
    ST_OPC, ST_ADDR, ST_DUMMY, ST_RDATA, ST_RSTAT, ST_WSDATA, ST_PDATA, ST_END, ST_IGNORE
  } sfc_spi_st_t;

  // Self-timed cycle states.
  typedef enum logic [1:0] {
    WK_IDLE, WK_COPY, WK_WAIT
  } sfc_work_st_t;

endpackage

// [verilog/sfc_mem_if.sv]
`timescale 1ns/1ps
// Link between the instruction core and the storage array.
interface sfc_mem_if #(parameter int AW = 16);
  logic [AW-1:0]     rd_addr;  // Combinational read address.
  sfc_pkg::sfc_byte_t rd_data; // Byte at rd_addr.
  logic              wr_en;    // Write strobe.
  logic [AW-1:0]     wr_addr;  // Write address.
  sfc_pkg::sfc_byte_t wr_data; // Write byte.
  modport core  (output rd_addr, wr_en, wr_addr, wr_data, input rd_data);
  modport store (input rd_addr, wr_en, wr_addr, wr_data, output rd_data);
endinterface

// [verilog/sfc_array.sv]
`timescale 1ns/1ps
// Byte-wide storage array with an asynchronous read port.
module sfc_array #(
  parameter int AW = 16
) (
  input wire logic   ref_clk,
  sfc_mem_if.store   mem
);
  import sfc_pkg::*;

  // The array starts erased; an initialiser keeps the clocked writer the only process on it.
  sfc_byte_t cells [0:(1<<AW)-1] = '{default: 8'hFF};  // Array contents.

  // Writes land on the clock; no reset because this is bulk storage.
  always_ff @(posedge ref_clk) begin
    if (mem.wr_en) begin
      cells[mem.wr_addr] <= mem.wr_data;
    end
  end

  // Reads are combinational so a byte is ready at the next link edge.
  assign mem.rd_data = cells[mem.rd_addr];

endmodule

// [verilog/sfc_core.sv]
`timescale 1ns/1ps
`include "sfc_cfg.svh"
module sfc_core #(
  parameter int MEM_AW  = 16,
  parameter int TW_CYC  = `SFC_TW_CYC,
  parameter int TPP_CYC = `SFC_TPP_CYC
) (
  input  wire logic ref_clk,
  input  wire logic resetn,
  input  wire logic cs_n,
  input  wire logic sclk,
  input  wire logic serial_in_pin,
  input  wire logic wp_n,
  output logic      serial_out,
  output logic      serial_out_oe
);
  import sfc_pkg::*;

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!resetn);

  logic [3:0]    pin_raw;      // Raw pins: guard, data in, clock, select.
  logic [3:0]    meta_q;       // First synchroniser stage.
  logic [3:0]    sync_q;       // Second synchroniser stage.
  logic          sclk_prev_q;  // Last synchronised clock level.
  logic          sck_rise;     // Link clock rose, frame open.
  logic          sck_fall;     // Link clock fell, frame open.
  logic          cs_high;      // Synchronised select is idle.
  logic          cs_prev_q;    // Last synchronised select level.
  logic          cs_rise;      // Select just went idle.
  logic [7:0]    rx_q;         // Input shifter.
  logic [2:0]    bit_q;        // Bit position inside the byte.
  logic          byte_done;    // Eighth bit of a byte sampled.
  sfc_byte_t     rx_byte;      // The byte completing now.
  logic          bnd;          // Frame sits on a byte boundary.
  sfc_spi_st_t   state_q;      // Frame decoder state.
  sfc_byte_t     op_q;         // Opcode of the current frame.
  logic [1:0]    acnt_q;       // Address bytes taken.
  logic [23:0]   addr_q;       // Frame address.
  sfc_byte_t     ws_q;         // Pending status write value.
  logic [7:0]    col_q;        // Page buffer column.
  logic [1:0]    dcnt_q;       // Program data bytes, saturating.
  logic          pp_open;      // Program address just completed.
  logic          pd_wr;        // Program data byte arrived.
  sfc_byte_t     pbuf [0:`SFC_PAGE_BYTES-1];  // Page staging buffer.
  logic [`SFC_PAGE_BYTES-1:0] pmask_q;        // Columns sent this frame.
  logic          wel_q;        // Write latch.
  logic          lock_q;       // Status lock bit.
  logic [2:0]    guard_q;      // Block guard bits.
  logic          busy_q;       // Self-timed cycle running.
  sfc_work_st_t  wk_q;         // Self-timed cycle state.
  logic [23:0]   wcnt_q;       // Cycle timer.
  logic [7:0]    cpy_q;        // Copy column.
  sfc_byte_t     status_word;  // Status as the host sees it.
  logic          go_wren;      // Execute write-latch set.
  logic          go_wrdi;      // Execute write-latch clear.
  logic          go_wsr;       // Execute status write.
  logic          go_pp;        // Execute page program.
  logic          pp_prot;      // Target page is guarded.
  logic [7:0]    tx_q;         // Output shifter.
  logic [2:0]    obit_q;       // Output bit position.
  sfc_byte_t     ld_byte;      // Byte loaded at the start of an output slot.
  sfc_mem_if #(.AW(MEM_AW)) mem ();

  // Guarded region: top 1/2^(7-g) of the array, g = 7 guards all.
  function automatic logic prot_hit(input logic [2:0] g, input logic [MEM_AW-1:0] a);
    return (g == 3'h7) || (g != 3'h0 && ((~a) >> (MEM_AW - 7 + int'(g))) == '0);
  endfunction

  // Every pin crosses two flops; the first is read only by the second.
  assign pin_raw = {wp_n, serial_in_pin, sclk, cs_n};
  generate
    for (genvar g = 0; g < 4; g++) begin : g_sync
      always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
          meta_q[g] <= 1'b1;
          sync_q[g] <= 1'b1;
        end else begin
          meta_q[g] <= pin_raw[g];
          sync_q[g] <= meta_q[g];
        end
      end
    end
  endgenerate

  // Edge history for the link clock and select.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      sclk_prev_q <= 1'b1;
      cs_prev_q   <= 1'b1;
    end else begin
      sclk_prev_q <= sync_q[1];
      cs_prev_q   <= sync_q[0];
    end
  end

  // Link edges count only inside a frame, so idle clock toggles are harmless.
  assign cs_high   = sync_q[0];
  assign cs_rise   = sync_q[0] & ~cs_prev_q;
  assign sck_rise  = ~cs_high & sync_q[1] & ~sclk_prev_q;
  assign sck_fall  = ~cs_high & ~sync_q[1] & sclk_prev_q;
  assign byte_done = sck_rise & (bit_q == 3'h7);
  assign rx_byte   = {rx_q[6:0], sync_q[2]};
  assign bnd       = (bit_q == 3'h0);

  // Input bits are sampled on rising link edges, MSB first.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      rx_q  <= 8'h00;
      bit_q <= 3'h0;
    end else if (cs_high) begin
      bit_q <= 3'h0;
    end else if (sck_rise) begin
      rx_q  <= rx_byte;
      bit_q <= bit_q + 3'h1;
    end
  end

  // Frame decoder; the opcode decides whether the frame is taken at all.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      state_q <= ST_OPC;
      op_q    <= 8'h00;
      acnt_q  <= 2'h0;
      addr_q  <= 24'h000000;
      ws_q    <= 8'h00;
    end else if (cs_high) begin
      state_q <= ST_OPC;
    end else if (byte_done) begin
      unique case (state_q)
        ST_OPC: begin
          op_q   <= rx_byte;
          acnt_q <= 2'h0;
          if (busy_q && rx_byte != `SFC_OP_RDSR) begin
            state_q <= ST_IGNORE;
          end else begin
            unique case (rx_byte)
              `SFC_OP_WREN, `SFC_OP_WRDI: state_q <= ST_END;
              `SFC_OP_RDSR: state_q <= ST_RSTAT;
              `SFC_OP_WRSR: state_q <= wel_q ? ST_WSDATA : ST_IGNORE;
              `SFC_OP_READ, `SFC_OP_FREAD: state_q <= ST_ADDR;
              `SFC_OP_PP: state_q <= wel_q ? ST_ADDR : ST_IGNORE;
              default: state_q <= ST_IGNORE;
            endcase
          end
        end
        ST_ADDR: begin
          addr_q <= {addr_q[15:0], rx_byte};
          acnt_q <= acnt_q + 2'h1;
          if (acnt_q == `SFC_ADDR_BYTES - 2'h1) begin
            state_q <= (op_q == `SFC_OP_FREAD) ? ST_DUMMY :
                       (op_q == `SFC_OP_PP)    ? ST_PDATA : ST_RDATA;
          end
        end
        ST_DUMMY: state_q <= ST_RDATA;
        ST_WSDATA: begin
          ws_q    <= rx_byte;
          state_q <= ST_END;
        end
        ST_END: state_q <= ST_IGNORE;
        ST_RDATA, ST_RSTAT, ST_PDATA, ST_IGNORE: state_q <= state_q;
      endcase
    end else if (sck_fall && state_q == ST_RDATA && obit_q == 3'h0) begin
      addr_q <= addr_q + 24'h000001;
    end
  end

  // Program data lands in the page buffer; the column wraps in the page.
  assign pp_open = byte_done && state_q == ST_ADDR && acnt_q == `SFC_ADDR_BYTES - 2'h1
                   && op_q == `SFC_OP_PP;
  assign pd_wr   = byte_done && state_q == ST_PDATA;

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      col_q   <= 8'h00;
      dcnt_q  <= 2'h0;
      pmask_q <= '0;
    end else if (pp_open) begin
      col_q   <= rx_byte;
      dcnt_q  <= 2'h0;
      pmask_q <= '0;
    end else if (pd_wr) begin
      col_q           <= col_q + 8'h01;
      pmask_q[col_q]  <= 1'b1;
      if (dcnt_q != `SFC_MIN_PP_DATA) begin
        dcnt_q <= dcnt_q + 2'h1;
      end
    end
  end

  // Buffer storage needs no reset: the mask says which columns are real.
  always_ff @(posedge ref_clk) begin
    if (pd_wr) begin
      pbuf[col_q] <= rx_byte;
    end
  end

  // Write commands act only when select rises on a byte boundary.
  assign pp_prot = prot_hit(guard_q, addr_q[MEM_AW-1:0]);
  assign go_wren = cs_rise && bnd && state_q == ST_END && op_q == `SFC_OP_WREN;
  assign go_wrdi = cs_rise && bnd && state_q == ST_END && op_q == `SFC_OP_WRDI;
  assign go_wsr  = cs_rise && bnd && state_q == ST_END && op_q == `SFC_OP_WRSR
                   && !(lock_q && !sync_q[3]);
  assign go_pp   = cs_rise && bnd && state_q == ST_PDATA
                   && dcnt_q == `SFC_MIN_PP_DATA && !pp_prot;

  // Write latch; cleared at reset and when any write cycle begins.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      wel_q <= 1'(`SFC_ST_RESET >> `SFC_ST_WEL);
    end else if (go_wren) begin
      wel_q <= 1'b1;
    end else if (go_wrdi || go_wsr || go_pp) begin
      wel_q <= 1'b0;
    end
  end

  // Writable status bits; the new value shows as the cycle starts.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      lock_q  <= 1'b0;
      guard_q <= 3'h0;
    end else if (go_wsr) begin
      lock_q  <= ws_q[`SFC_ST_LOCK];
      guard_q <= ws_q[`SFC_ST_GUARD2:`SFC_ST_GUARD0];
    end
  end

  // Self-timed cycles: program copies marked columns, then both wait out a timer.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      wk_q   <= WK_IDLE;
      busy_q <= 1'b0;
      wcnt_q <= 24'h000000;
      cpy_q  <= 8'h00;
    end else begin
      unique case (wk_q)
        WK_IDLE: begin
          if (go_wsr) begin
            busy_q <= 1'b1;
            wcnt_q <= 24'(TW_CYC - 1);
            wk_q   <= WK_WAIT;
          end else if (go_pp) begin
            busy_q <= 1'b1;
            cpy_q  <= 8'h00;
            wk_q   <= WK_COPY;
          end
        end
        WK_COPY: begin
          cpy_q <= cpy_q + 8'h01;
          if (cpy_q == 8'(`SFC_PAGE_BYTES - 1)) begin
            wcnt_q <= 24'(TPP_CYC - 1);
            wk_q   <= WK_WAIT;
          end
        end
        WK_WAIT: begin
          if (wcnt_q == 24'h000000) begin
            busy_q <= 1'b0;
            wk_q   <= WK_IDLE;
          end else begin
            wcnt_q <= wcnt_q - 24'h000001;
          end
        end
      endcase
    end
  end

  // Only columns sent in the frame are written; others keep their bytes.
  assign mem.wr_en   = (wk_q == WK_COPY) && pmask_q[cpy_q];
  assign mem.wr_addr = {addr_q[MEM_AW-1:8], cpy_q};
  assign mem.wr_data = pbuf[cpy_q];
  assign mem.rd_addr = addr_q[MEM_AW-1:0];

  sfc_array #(.AW(MEM_AW)) u_array (
    .ref_clk (ref_clk),
    .mem     (mem)
  );

  // Reserved bits 6 and 5 read as zero.
  assign status_word = {lock_q, 2'b00, guard_q, wel_q, busy_q};
  // Status is re-read each byte so the host sees busy drop live.
  assign ld_byte     = (state_q == ST_RSTAT) ? status_word : mem.rd_data;

  // Output shifter; bytes load on the first falling edge of each byte slot.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      serial_out    <= 1'b0;
      serial_out_oe <= 1'b0;
      tx_q          <= 8'h00;
      obit_q        <= 3'h0;
    end else if (cs_high) begin
      serial_out_oe <= 1'b0;
      obit_q        <= 3'h0;
    end else if (sck_fall && (state_q == ST_RDATA || state_q == ST_RSTAT)) begin
      serial_out_oe <= 1'b1;
      obit_q        <= obit_q + 3'h1;
      if (obit_q == 3'h0) begin
        serial_out <= ld_byte[7];
        tx_q       <= {ld_byte[6:0], 1'b0};
      end else begin
        serial_out <= tx_q[7];
        tx_q       <= {tx_q[6:0], 1'b0};
      end
    end
  end

  // Checks on the frame and cycle behaviour.
  sequence s_opc_byte;
    byte_done && state_q == ST_OPC;
  endsequence
  sequence s_wsr_end;
    cs_rise && bnd && state_q == ST_END && op_q == `SFC_OP_WRSR;
  endsequence
  wel_set_a: assert property (go_wren |=> wel_q) else $error("write latch not set");
  wel_clear_a: assert property (go_wrdi |=> !wel_q) else $error("latch not cleared");
  busy_drop_a: assert property (
    s_opc_byte ##0 (busy_q && rx_byte != `SFC_OP_RDSR) |=> state_q == ST_IGNORE)
    else $error("instruction taken while busy");
  poll_busy_a: assert property (
    s_opc_byte ##0 (rx_byte == `SFC_OP_RDSR) |=> state_q == ST_RSTAT)
    else $error("status read refused");
  wsr_start_a: assert property (go_wsr |=> busy_q && !wel_q && status_word[6:5] == 2'b00)
    else $error("status write start wrong");
  wsr_lock_a: assert property (
    s_wsr_end ##0 (lock_q && !sync_q[3]) |=> !busy_q && $stable(guard_q))
    else $error("locked status write executed");
  torn_frame_a: assert property (cs_rise && !bnd && !busy_q |=> !busy_q)
    else $error("unaligned frame started a cycle");
  page_wrap_a: assert property (pd_wr |=> col_q == $past(col_q) + 8'h01)
    else $error("page column did not advance");
  read_adv_a: assert property (
    sck_fall && state_q == ST_RDATA && obit_q == 3'h0 |=> addr_q == $past(addr_q) + 24'h1)
    else $error("read address did not advance");
  busy_hold_a: assert property ($rose(busy_q) |-> busy_q [*8])
    else $error("busy dropped too early");
  guard_skip_a: assert property (cs_rise && state_q == ST_PDATA && pp_prot |=> !busy_q)
    else $error("guarded page programmed");

endmodule

// [dv/sfc_host_model.sv]
`timescale 1ns/1ps
// Host controller in link mode 0: the clock idles low and stands still between frames.
module sfc_host_model (
  input  wire logic ref_clk,
  output logic      cs_n,
  output logic      sclk,
  output logic      serial_in_pin,
  input  wire logic serial_out,
  input  wire logic serial_out_oe
);
  localparam int HALF = 4;  // Half of the 400 ns link period, in system clocks.

  // Idle levels before the first frame.
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    serial_in_pin = 1'b1;
  end

  // Every pin change lands on a falling system clock edge, away from the sampling edge.
  task automatic idle(input int n);
    repeat (n) @(negedge ref_clk);
  endtask

  // One framed transfer: tx bytes, then nrd bytes read back, then xb stray bits.
  task automatic frame(input logic [7:0] tx[$], input int xb, input int nrd,
                       output logic [7:0] rx[$], output logic oe);
    logic [7:0] sh;
    int         nb;
    int         nt;
    rx = {};
    oe = 1'b0;
    sh = 8'h00;
    nt = 8 * tx.size();
    nb = nt + 8 * nrd + xb;
    idle(1);
    cs_n = 1'b0;
    idle(HALF);
    for (int i = 0; i < nb; i++) begin
      // Bits past the command are don't-care, so they toggle at random to expose stale reads.
      serial_in_pin = (i < nt) ? tx[i / 8][7 - i % 8] : 1'($urandom);
      idle(HALF);
      sclk = 1'b1;
      // A released line has no pull, so it reads as the inverse and a missing enable shows.
      sh = {sh[6:0], serial_out_oe ? serial_out : ~serial_out};
      oe = oe | (serial_out_oe === 1'b1);
      if (i >= nt && i < nt + 8 * nrd && (i - nt) % 8 == 7) begin
        rx.push_back(sh);
      end
      idle(HALF);
      sclk = 1'b0;
    end
    // Select stays low through the last byte, then a gap well above the minimum.
    idle(HALF);
    cs_n = 1'b1;
    idle(8);
  endtask
endmodule

// [dv/serial_flash_cmd_core_tb.sv]
`timescale 1ns/1ps
`include "sfc_cfg.svh"
module serial_flash_cmd_core_tb;
  import sfc_pkg::*;
  localparam int AW    = 12;        // Small array keeps reads and fills short.
  localparam int MEMSZ = 1 << AW;   // Array size in bytes.
  localparam int TW    = 400;       // Long enough to catch busy on the first status byte.
  localparam int TPP   = 1000;      // Busy must outlast the refused read, fast read and set frames.

  logic      ref_clk;
  logic      resetn;
  logic      wp_n;
  logic      cs_n;
  logic      sclk;
  logic      serial_in_pin;
  logic      serial_out;
  logic      serial_out_oe;
  sfc_byte_t st;                // Reference status word.
  sfc_byte_t mem [MEMSZ];       // Reference array.
  int        fails = 0;         // Mismatches seen.
  int        compares = 0;      // Comparisons made.

  sfc_core #(.MEM_AW(AW), .TW_CYC(TW), .TPP_CYC(TPP)) u_sfc_core (
    .ref_clk       (ref_clk),
    .resetn        (resetn),
    .cs_n          (cs_n),
    .sclk          (sclk),
    .serial_in_pin (serial_in_pin),
    .wp_n          (wp_n),
    .serial_out    (serial_out),
    .serial_out_oe (serial_out_oe)
  );

  sfc_host_model u_sfc_host_model (
    .ref_clk       (ref_clk),
    .cs_n          (cs_n),
    .sclk          (sclk),
    .serial_in_pin (serial_in_pin),
    .serial_out    (serial_out),
    .serial_out_oe (serial_out_oe)
  );

  // System clock of 50 ns.
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  // Prints the counts and the verdict, then stops.
  task automatic complete_run;
    $display("fails=%0d compares=%0d", fails, compares);
    if (fails == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Compares a byte read off the link.
  task automatic chk_byte(input sfc_byte_t got, input sfc_byte_t exp);
    compares++;
    if (got !== exp) begin
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      fails++;
    end
  endtask

  // Compares whether the output enable rose during a frame.
  task automatic chk_flag(input logic got, input logic exp);
    compares++;
    if (got !== exp) begin
      $display("BAD t=%0t oe got=%h exp=%h", $time, got, exp);
      fails++;
    end
  endtask

  // Guard map: 0 none, 7 all, otherwise the top 1/2^(7-g) of the array.
  function automatic bit guarded(input int a);
    int g;
    g = int'(st[4:2]);
    return g == 7 || (g != 0 && a >= MEMSZ - (MEMSZ >> (7 - g)));
  endfunction

  // Runs one frame, then replays it on the reference model and checks the answer.
  task automatic xfer(input sfc_byte_t tx[$], input int xb, input int nrd);
    sfc_byte_t rx[$];
    logic      oe;
    sfc_byte_t op;
    bit        on;
    bit        rd;
    int        n;
    int        a;
    u_sfc_host_model.frame(tx, xb, nrd, rx, oe);
    op = tx[0];
    n = tx.size();
    on = !st[0] || op == `SFC_OP_RDSR;
    a = (n > 3) ? int'({tx[1], tx[2], tx[3]}) % MEMSZ : 0;
    rd = op == `SFC_OP_RDSR || op == `SFC_OP_READ || op == `SFC_OP_FREAD;
    chk_flag(oe, on && rd && nrd > 0);
    if (on) begin
      case (op)
        `SFC_OP_RDSR: for (int k = 0; k < nrd; k++) chk_byte(rx[k], st);
        `SFC_OP_READ, `SFC_OP_FREAD: for (int k = 0; k < nrd; k++) begin
          chk_byte(rx[k], mem[(a + k) % MEMSZ]);
        end
        `SFC_OP_WREN: if (n == 1) st[1] = 1'b1;
        `SFC_OP_WRDI: if (n == 1) st[1] = 1'b0;
        `SFC_OP_WRSR: if (n == 2 && xb == 0 && st[1] && !(st[7] && !wp_n)) begin
          st = (st & 8'h60) | (tx[1] & 8'h9C) | 8'h01;
        end
        `SFC_OP_PP: if (n >= 6 && xb == 0 && st[1] && !guarded(a)) begin
          for (int k = 4; k < n; k++) mem[(a & ~255) + ((a + k - 4) & 255)] = tx[k];
          st = (st & 8'hFC) | 8'h01;
        end
        default: ;
      endcase
    end
  endtask

  // Polls the status word until busy drops, with a bounded number of polls.
  task automatic wait_ready;
    sfc_byte_t rx[$];
    logic      oe;
    for (int i = 0; i < 40; i++) begin
      u_sfc_host_model.frame({`SFC_OP_RDSR}, 0, 1, rx, oe);
      if (rx[0][0] === 1'b0) st[0] = 1'b0;
      chk_byte(rx[0], st);
      if (st[0] == 1'b0) return;
    end
    fails++;
    complete_run();
  endtask

  // Main sequence.
  initial begin
    sfc_byte_t q[$];
    int        seed;
    resetn = 1'b0;
    wp_n = 1'b1;
    st = 8'h00;
    seed = $urandom(32'hD5A6);
    for (int i = 0; i < MEMSZ; i++) mem[i] = 8'hFF;
    repeat (10) @(negedge ref_clk);
    resetn = 1'b1;
    repeat (4) @(negedge ref_clk);
    xfer({`SFC_OP_RDSR}, 0, 2);
    xfer({8'hC3}, 0, 1);
    xfer({`SFC_OP_WREN}, 0, 0);
    xfer({`SFC_OP_RDSR}, 0, 1);
    xfer({`SFC_OP_WRDI}, 0, 0);
    xfer({`SFC_OP_WREN, 8'hA5}, 0, 0);
    xfer({`SFC_OP_WRSR, 8'hFF}, 0, 0);
    xfer({`SFC_OP_WREN}, 0, 0);
    xfer({`SFC_OP_WRSR, 8'hFF}, 3, 0);
    xfer({`SFC_OP_RDSR}, 0, 1);
    xfer({`SFC_OP_WRSR, 8'hFF}, 0, 0);
    xfer({`SFC_OP_RDSR}, 0, 2);
    wait_ready();
    // Lock set and every page guarded: a low guard pin must hold the status word.
    wp_n = 1'b0;
    xfer({`SFC_OP_WREN}, 0, 0);
    xfer({`SFC_OP_WRSR, 8'h00}, 0, 0);
    xfer({`SFC_OP_PP, 8'h00, 8'h01, 8'h00, 8'h12, 8'h34}, 0, 0);
    xfer({`SFC_OP_RDSR}, 0, 1);
    wp_n = 1'b1;
    xfer({`SFC_OP_WRSR, 8'h00}, 0, 0);
    wait_ready();
    // Short program that wraps inside its page, with traffic refused while busy.
    q = {`SFC_OP_PP, 8'h00, 8'h01, 8'hFC};
    repeat (6) q.push_back(sfc_byte_t'($urandom));
    xfer({`SFC_OP_WREN}, 0, 0);
    xfer(q, 0, 0);
    xfer({`SFC_OP_READ, 8'h00, 8'h01, 8'h00}, 0, 1);
    xfer({`SFC_OP_FREAD, 8'h00, 8'h01, 8'h00, 8'h00}, 0, 1);
    xfer({`SFC_OP_WREN}, 0, 0);
    xfer({`SFC_OP_RDSR}, 0, 1);
    wait_ready();
    xfer({`SFC_OP_READ, 8'h00, 8'h01, 8'hFA}, 0, 8);
    xfer({`SFC_OP_FREAD, 8'h00, 8'h01, 8'h00, 8'h5A}, 0, 3);
    // Too few data bytes, then no write latch: both programs are refused.
    xfer({`SFC_OP_WREN}, 0, 0);
    xfer({`SFC_OP_PP, 8'h00, 8'h03, 8'h00, 8'h00}, 0, 0);
    xfer({`SFC_OP_WRDI}, 0, 0);
    xfer({`SFC_OP_PP, 8'h00, 8'h03, 8'h00, 8'h00, 8'h00}, 0, 0);
    xfer({`SFC_OP_READ, 8'h00, 8'h03, 8'h00}, 0, 2);
    // More than a page of data: the last bytes overwrite the first columns.
    q = {`SFC_OP_PP, 8'h00, 8'h02, 8'h00};
    repeat (258) q.push_back(sfc_byte_t'($urandom));
    xfer({`SFC_OP_WREN}, 0, 0);
    xfer(q, 0, 0);
    wait_ready();
    // A mid-run reset clears the write latch but keeps the array.
    xfer({`SFC_OP_WREN}, 0, 0);
    resetn = 1'b0;
    repeat (10) @(negedge ref_clk);
    resetn = 1'b1;
    st = 8'h00;
    repeat (4) @(negedge ref_clk);
    xfer({`SFC_OP_READ, 8'h00, 8'h02, 8'h00}, 0, 6);
    xfer({`SFC_OP_RDSR}, 0, 1);
    complete_run();
  end
endmodule
